// ---- logic/pmcc_map.vh ----
// Constants for the power mode and clock controller: register offsets,
// field positions, reset values and timing counts.
// Assumes inclusion by its bare name from the controller's design file.
`ifndef PMCC_MAP_VH
`define PMCC_MAP_VH
// Register byte offsets on the Wishbone slave (word aligned)
`define PMCC_ADR_PLLCTL 5'h00
`define PMCC_ADR_PLLDIV 5'h04
`define PMCC_ADR_REGULATOR_CTRL_REG 5'h08
`define PMCC_ADR_LOCKCNT 5'h0C
`define PMCC_ADR_STATUS 5'h10
// pll_control_reg fields
`define PMCC_MULT_LSB 0
`define PMCC_MULT_MSB 4
`define PMCC_BYPASS_BIT 8
`define PMCC_PLLOFF_BIT 9
`define PMCC_SLEEP_BIT 10
`define PMCC_DEEP_BIT 11
// Divider register fields
`define PMCC_SSEL_LSB 0
`define PMCC_SSEL_MSB 3
`define PMCC_CSEL_LSB 4
`define PMCC_CSEL_MSB 5
// regulator_ctrl_reg fields
`define PMCC_VLVL_LSB 0
`define PMCC_VLVL_MSB 3
`define PMCC_VREN_BIT 4
`define PMCC_VRBYP_BIT 5
// Status register fields
`define PMCC_ST_MODE_LSB 0
`define PMCC_ST_MODE_MSB 3
`define PMCC_ST_LOCK_BIT 4
`define PMCC_ST_MULT_LSB 8
`define PMCC_ST_MULT_MSB 12
// Reset values
`define PMCC_MULT_RST 5'h0A
`define PMCC_SSEL_RST 4'h5
`define PMCC_CSEL_RST 2'h0
`define PMCC_VLVL_RST 4'h8
`define PMCC_LOCK_RST 16'h0200
// Regulator step in millivolts per code
`define PMCC_VSTEP_MV 50
`endif

// ---- logic/pmcc_top.v ----
// Power mode and clock controller: four operating modes, core and system
// clock enables from glitch-free dividers, PLL multiplier with lock wait,
// regulator setting, all behind a classic Wishbone slave.
// Assumes one 100 MHz reference clock; faster clocks are modelled as
// one-cycle enable pulses, so the PLL output is modelled at the ref rate.
//
// Functional notes
// - Reset enters Full On, PLL running, clocks on
// - Active bypasses PLL, core at reference rate
// - New multiplier applied only after lock count
// - DMA to L1 granted Active, refused Sleep
// - Sleep stops core clock, PLL and system run
// - Interrupt wakes Sleep to Full On or Active
// - Deep Sleep stops core, system clock, PLL
// - Deep Sleep exits on reset or RTC
// - Deep Sleep blocks async units from resources
// - Regulator level in 50 mV steps, disable, bypass
// - Multiplier 1x to 31x, default 10x
// - System clock is PLL output over 1-15
// - System divider field is plain binary ratio
// - System divider change needs no lock wait
// - Core divider codes give 1, 2, 4, 8
//
// The Wishbone slave port and the register addresses were decided locally.
`timescale 1ns/1ps
`include "pmcc_map.vh"
module pmcc_top (
    input wire REF_CLK_I, // Reference clock, 100 MHz
    input wire RESET_I, // Asynchronous reset, active high
    input wire WB_CYC_I, // Wishbone cycle
    input wire WB_STB_I, // Wishbone strobe
    input wire WB_WE_I, // Wishbone write enable
    input wire [4:0] WB_ADR_I, // Wishbone byte address
    input wire [3:0] WB_SEL_I, // Wishbone byte lanes
    input wire [31:0] WB_DAT_I, // Wishbone write data
    output reg [31:0] WB_DAT_O, // Wishbone read data
    output reg WB_ACK_O, // Wishbone acknowledge
    input wire IRQ_I, // Any asserted interrupt
    input wire RTC_WAKE_I, // RTC asynchronous wake interrupt
    output reg CORE_CLK_EN_O, // core_clock enable pulse
    output reg SYS_CLK_EN_O, // System clock enable pulse
    output reg PLL_EN_O, // PLL powered
    output reg PLL_BYPASS_O, // PLL output bypassed
    output reg [4:0] PLL_MULT_O, // Multiplier in use
    output reg DMA_L1_GRANT_O, // System DMA may reach L1
    output reg ASYNC_BLOCK_O, // Async units kept off resources
    output reg [3:0] VREG_LEVEL_O, // Regulator code, 50 mV per step
    output reg VREG_EN_O, // Regulator enabled
    output reg VREG_BYPASS_O, // Regulator bypassed
    output reg [3:0] MODE_O // One-hot mode: deep,sleep,active,full
);

////////////////////////////////////////////////////////////////////////////////
// Mode states, one-hot
localparam [3:0] ST_FULL = 4'h1;
localparam [3:0] ST_ACT = 4'h2;
localparam [3:0] ST_SLP = 4'h4;
localparam [3:0] ST_DEEP = 4'h8;

// Core divider code to divide-by minus one
function [2:0] csel_last;
    input [1:0] code;
    begin
        case (code)
            2'h0: csel_last = 3'h0;
            2'h1: csel_last = 3'h1;
            2'h2: csel_last = 3'h3;
            default: csel_last = 3'h7;
        endcase
    end
endfunction

reg [3:0] mode_q;
reg [3:0] mode_d;
reg [4:0] mult_req_q;
reg bypass_q;
reg plloff_q;
reg slp_pend_q;
reg deep_pend_q;
reg [3:0] ssel_q;
reg [1:0] csel_q;
reg [3:0] vlvl_q;
reg vren_q;
reg vrbyp_q;
reg [15:0] lock_cnt_q;
reg [15:0] lock_tmr_q;
reg lock_busy_q;
reg [3:0] sdiv_q;
reg [3:0] sratio_q;
reg [2:0] cdiv_q;
reg [2:0] cratio_q;
wire acc;
wire wr;
wire [4:0] wmult;
wire [3:0] wssel;
wire core_run;
wire sys_run;

assign acc = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
assign wr = acc & WB_WE_I;
assign wmult = WB_DAT_I[`PMCC_MULT_MSB:`PMCC_MULT_LSB];
assign wssel = WB_DAT_I[`PMCC_SSEL_MSB:`PMCC_SSEL_LSB];
// Clocks run per mode table; Sleep and Deep Sleep stop the core clock
assign core_run = mode_q[0] | mode_q[1];
assign sys_run = ~mode_q[3];

////////////////////////////////////////////////////////////////////////////////
// Bus slave: one registered ack per access, a cycle after the strobe, unmapped reads return zero
always @(posedge REF_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
        WB_ACK_O <= 1'b0;
        WB_DAT_O <= 32'h00000000;
    end else begin
        WB_ACK_O <= acc;
        if (acc & ~WB_WE_I) begin
            case (WB_ADR_I)
                `PMCC_ADR_PLLCTL: WB_DAT_O <= {20'h00000, 2'h0, plloff_q, bypass_q,
                                               3'h0, mult_req_q};
                `PMCC_ADR_PLLDIV: WB_DAT_O <= {26'h0000000, csel_q, ssel_q};
                `PMCC_ADR_REGULATOR_CTRL_REG: WB_DAT_O <= {26'h0000000, vrbyp_q, vren_q, vlvl_q};
                `PMCC_ADR_LOCKCNT: WB_DAT_O <= {16'h0000, lock_cnt_q};
                `PMCC_ADR_STATUS: WB_DAT_O <= {19'h00000, PLL_MULT_O, 3'h0,
                                               ~lock_busy_q, mode_q};
                default: WB_DAT_O <= 32'h00000000;
            endcase
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Software registers; zero ratios are illegal and leave the field as it was
always @(posedge REF_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
        mult_req_q <= `PMCC_MULT_RST;
        bypass_q <= 1'b0;
        plloff_q <= 1'b0;
        ssel_q <= `PMCC_SSEL_RST;
        csel_q <= `PMCC_CSEL_RST;
        vlvl_q <= `PMCC_VLVL_RST;
        vren_q <= 1'b1;
        vrbyp_q <= 1'b0;
        lock_cnt_q <= `PMCC_LOCK_RST;
    end else begin
        // Waking from Deep Sleep lands in Full On, so bypass is dropped
        if (mode_q[3] & RTC_WAKE_I) begin
            bypass_q <= 1'b0;
        end else if (wr && WB_ADR_I == `PMCC_ADR_PLLCTL && WB_SEL_I[1]) begin
            bypass_q <= WB_DAT_I[`PMCC_BYPASS_BIT];
            plloff_q <= WB_DAT_I[`PMCC_PLLOFF_BIT];
        end
        if (wr && WB_ADR_I == `PMCC_ADR_PLLCTL && WB_SEL_I[0] && wmult != 5'h00) begin
            mult_req_q <= wmult;
        end
        if (wr && WB_ADR_I == `PMCC_ADR_PLLDIV && WB_SEL_I[0]) begin
            if (wssel != 4'h0) begin
                ssel_q <= wssel;
            end
            csel_q <= WB_DAT_I[`PMCC_CSEL_MSB:`PMCC_CSEL_LSB];
        end
        if (wr && WB_ADR_I == `PMCC_ADR_REGULATOR_CTRL_REG && WB_SEL_I[0]) begin
            vlvl_q <= WB_DAT_I[`PMCC_VLVL_MSB:`PMCC_VLVL_LSB];
            vren_q <= WB_DAT_I[`PMCC_VREN_BIT];
            vrbyp_q <= WB_DAT_I[`PMCC_VRBYP_BIT];
        end
        if (wr && WB_ADR_I == `PMCC_ADR_LOCKCNT) begin
            if (WB_SEL_I[0]) begin
                lock_cnt_q[7:0] <= WB_DAT_I[7:0];
            end
            if (WB_SEL_I[1]) begin
                lock_cnt_q[15:8] <= WB_DAT_I[15:8];
            end
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Lock timer: a new multiplier, or PLL restart on Deep Sleep wake, waits out the lock count
always @(posedge REF_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
        lock_tmr_q <= 16'h0000;
        lock_busy_q <= 1'b0;
        PLL_MULT_O <= `PMCC_MULT_RST;
    end else if ((mode_q[3] & RTC_WAKE_I) ||
                 (wr && WB_ADR_I == `PMCC_ADR_PLLCTL && WB_SEL_I[0] && wmult != 5'h00)) begin
        lock_tmr_q <= lock_cnt_q;
        lock_busy_q <= 1'b1;
    end else if (lock_busy_q & PLL_EN_O) begin
        if (lock_tmr_q == 16'h0000) begin
            lock_busy_q <= 1'b0;
            PLL_MULT_O <= mult_req_q;
        end else begin
            lock_tmr_q <= lock_tmr_q - 16'h0001;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Sleep requests are held until the requesting bus cycle has ended
always @(posedge REF_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
        slp_pend_q <= 1'b0;
        deep_pend_q <= 1'b0;
    end else if (wr && WB_ADR_I == `PMCC_ADR_PLLCTL && WB_SEL_I[1]) begin
        slp_pend_q <= WB_DAT_I[`PMCC_SLEEP_BIT];
        deep_pend_q <= WB_DAT_I[`PMCC_DEEP_BIT];
    end else if (~WB_CYC_I) begin
        slp_pend_q <= 1'b0;
        deep_pend_q <= 1'b0;
    end
end

// Mode selection; an interrupt in Sleep picks the target from bypass
always @* begin
    mode_d = mode_q;
    case (mode_q)
        ST_FULL, ST_ACT: begin
            if (deep_pend_q & ~WB_CYC_I) begin
                mode_d = ST_DEEP;
            end else if (slp_pend_q & ~WB_CYC_I) begin
                mode_d = ST_SLP;
            end else begin
                mode_d = bypass_q ? ST_ACT : ST_FULL;
            end
        end
        ST_SLP: begin
            if (IRQ_I) begin
                mode_d = bypass_q ? ST_ACT : ST_FULL;
            end
        end
        ST_DEEP: begin
            if (RTC_WAKE_I) begin
                mode_d = ST_FULL;
            end
        end
        default: mode_d = ST_FULL;
    endcase
end

always @(posedge REF_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
        mode_q <= ST_FULL;
    end else begin
        mode_q <= mode_d;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Dividers: new ratios load only at a terminal count, so no pulse is cut
// short; the system ratio needs no lock wait
always @(posedge REF_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
        sdiv_q <= 4'h0;
        sratio_q <= `PMCC_SSEL_RST;
        cdiv_q <= 3'h0;
        cratio_q <= 3'h0;
    end else begin
        if (sdiv_q + 4'h1 >= sratio_q) begin
            sdiv_q <= 4'h0;
            sratio_q <= ssel_q;
        end else begin
            sdiv_q <= sdiv_q + 4'h1;
        end
        // Bypass runs the core straight at the reference rate
        if (cdiv_q >= cratio_q) begin
            cdiv_q <= 3'h0;
            cratio_q <= bypass_q ? 3'h0 : csel_last(csel_q);
        end else begin
            cdiv_q <= cdiv_q + 3'h1;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Registered outputs; gating acts on whole enable pulses only
always @(posedge REF_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
        CORE_CLK_EN_O <= 1'b0;
        SYS_CLK_EN_O <= 1'b0;
        PLL_EN_O <= 1'b1;
        PLL_BYPASS_O <= 1'b0;
        DMA_L1_GRANT_O <= 1'b0;
        ASYNC_BLOCK_O <= 1'b0;
        VREG_LEVEL_O <= `PMCC_VLVL_RST;
        VREG_EN_O <= 1'b1;
        VREG_BYPASS_O <= 1'b0;
        MODE_O <= ST_FULL;
    end else begin
        CORE_CLK_EN_O <= core_run & (cdiv_q >= cratio_q);
        SYS_CLK_EN_O <= sys_run & (sdiv_q + 4'h1 >= sratio_q);
        // Active may power the PLL down; Deep Sleep always does
        PLL_EN_O <= ~mode_q[3] & ~(mode_q[1] & plloff_q);
        PLL_BYPASS_O <= mode_q[1];
        DMA_L1_GRANT_O <= mode_q[0] | mode_q[1];
        ASYNC_BLOCK_O <= mode_q[3];
        VREG_LEVEL_O <= vlvl_q;
        VREG_EN_O <= vren_q;
        VREG_BYPASS_O <= vrbyp_q;
        MODE_O <= mode_q;
    end
end

endmodule

// ---- tb/pmcc_props.sv ----
// Checker for the power mode controller: mode, clock and bus relations.
// Assumes binding to pmcc_top and a single reference clock domain.
`timescale 1ns/1ps
module pmcc_props (
    input wire REF_CLK_I, // Clock
    input wire RESET_I, // Reset
    input wire WB_CYC_I, // Cycle
    input wire WB_STB_I, // Strobe
    input wire WB_ACK_O, // Ack
    input wire IRQ_I, // Interrupt
    input wire RTC_WAKE_I, // RTC wake
    input wire CORE_CLK_EN_O, // Core tick
    input wire SYS_CLK_EN_O, // System tick
    input wire PLL_EN_O, // PLL on
    input wire PLL_BYPASS_O, // Bypass
    input wire DMA_L1_GRANT_O, // DMA grant
    input wire ASYNC_BLOCK_O, // Async block
    input wire [3:0] MODE_O // Mode
);
    default clocking @(posedge REF_CLK_I); endclocking
    default disable iff (RESET_I);
    // Mode guards span two edges, though every output settles on the same edge as MODE_O
    property p_ack;
        WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O ##1 !WB_ACK_O;
    endproperty
    a_ack: assert property (p_ack) else $error("ack not one cycle");
    property p_full;
        MODE_O[0] && $past(MODE_O[0]) |-> PLL_EN_O && !PLL_BYPASS_O;
    endproperty
    a_full: assert property (p_full) else $error("full on pll state");
    property p_act;
        MODE_O[1] && $past(MODE_O[1]) |-> PLL_BYPASS_O && DMA_L1_GRANT_O;
    endproperty
    a_act: assert property (p_act) else $error("active state");
    property p_slp;
        MODE_O[2] && $past(MODE_O[2]) |-> !CORE_CLK_EN_O && !DMA_L1_GRANT_O && PLL_EN_O;
    endproperty
    a_slp: assert property (p_slp) else $error("sleep state");
    property p_deep;
        MODE_O[3] && $past(MODE_O[3]) |->
            !CORE_CLK_EN_O && !SYS_CLK_EN_O && !PLL_EN_O && ASYNC_BLOCK_O;
    endproperty
    a_deep: assert property (p_deep) else $error("deep state");
    property p_wake;
        MODE_O[2] && IRQ_I |-> ##[1:2] (MODE_O[0] || MODE_O[1]);
    endproperty
    a_wake: assert property (p_wake) else $error("no wake");
    property p_stay;
        MODE_O[3] && !RTC_WAKE_I && !$past(RTC_WAKE_I) |=> MODE_O[3];
    endproperty
    a_stay: assert property (p_stay) else $error("left deep");
    property p_rtc;
        MODE_O[3] && RTC_WAKE_I |-> ##[1:2] MODE_O[0];
    endproperty
    a_rtc: assert property (p_rtc) else $error("rtc no wake");
    c_sleep: cover property (MODE_O[2] ##1 MODE_O[0]);
    c_deep: cover property (MODE_O[3] ##1 MODE_O[0]);
    c_act: cover property (MODE_O[1] && CORE_CLK_EN_O);
endmodule
bind pmcc_top pmcc_props u_props (.REF_CLK_I, .RESET_I, .WB_CYC_I, .WB_STB_I, .WB_ACK_O,
    .IRQ_I, .RTC_WAKE_I, .CORE_CLK_EN_O, .SYS_CLK_EN_O, .PLL_EN_O, .PLL_BYPASS_O,
    .DMA_L1_GRANT_O, .ASYNC_BLOCK_O, .MODE_O);

// ---- tb/pmcc_clk_sink.sv ----
// Model of the clock consumers: counts core and system clock ticks.
// Assumes the enables are one-cycle pulses on the reference clock.
`timescale 1ns/1ps
module pmcc_clk_sink (
    input wire clk_i, // Reference clock
    input wire rst_i, // Reset, active high
    input wire core_en_i, // Core tick
    input wire sys_en_i, // System tick
    output logic [31:0] core_cnt_o, // Core ticks seen
    output logic [31:0] sys_cnt_o // System ticks seen
);
    // Counting lets the bench judge ratios over whole windows, not edges
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            core_cnt_o <= 32'h0;
            sys_cnt_o <= 32'h0;
        end else begin
            core_cnt_o <= core_cnt_o + {31'h0, core_en_i};
            sys_cnt_o <= sys_cnt_o + {31'h0, sys_en_i};
        end
    end
endmodule

// ---- tb/testbench.sv ----
// Self-checking bench for pmcc_top: bus, modes, dividers, lock, regulator.
// Assumes pmcc_map.vh on the include path and the checker bound.
`timescale 1ns/1ps
`include "pmcc_map.vh"
module testbench;
    logic clk, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, irq = 1'b0, rtc = 1'b0;
    logic [4:0] adr = 5'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h0, rd;
    wire [31:0] dat_o, core_n, sys_n;
    wire ack, core_en, sys_en, pll_en, byp, dma, blk, ven, vbyp;
    wire [4:0] mult;
    wire [3:0] vlvl, mode;
    int n_mismatch = 0, checks_done = 0, cycles = 0, d, m, v;
    int sdiv[3] = '{1, 6, 15};
    pmcc_top dut (.REF_CLK_I(clk), .RESET_I(rst), .WB_CYC_I(cyc), .WB_STB_I(stb),
        .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(dat_o),
        .WB_ACK_O(ack), .IRQ_I(irq), .RTC_WAKE_I(rtc), .CORE_CLK_EN_O(core_en),
        .SYS_CLK_EN_O(sys_en), .PLL_EN_O(pll_en), .PLL_BYPASS_O(byp), .PLL_MULT_O(mult),
        .DMA_L1_GRANT_O(dma), .ASYNC_BLOCK_O(blk), .VREG_LEVEL_O(vlvl), .VREG_EN_O(ven),
        .VREG_BYPASS_O(vbyp), .MODE_O(mode));
    pmcc_clk_sink sink (.clk_i(clk), .rst_i(rst), .core_en_i(core_en), .sys_en_i(sys_en),
        .core_cnt_o(core_n), .sys_cnt_o(sys_n));
    ////////////////////////////////////////////////////////////////////////
    // Clock and hang guard; at most about 2000 cycles are needed
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            report_and_stop();
        end
    end
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // One classic cycle; waits for ack, then leaves the bus idle a cycle
    task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] val);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        sel <= 4'hF;
        adr <= a;
        wdat <= val;
        do @(posedge clk); while (ack !== 1'b1);
        rd = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        sel <= 4'h0;
        @(posedge clk);
    endtask
    // Ticks over a window of n cycles against the expected counts
    task automatic ticks(input int n, input int ec, input int es);
        logic [31:0] c0, s0;
        c0 = core_n;
        s0 = sys_n;
        repeat (n) @(posedge clk);
        chk(core_n - c0, 32'(ec));
        chk(sys_n - s0, 32'(es));
    endtask
    // Packed {dma, bypass, mode} expected after settling in Full On or Active
    function automatic logic [31:0] mode_exp(input int b);
        return b ? 32'h32 : 32'h21;
    endfunction
    ////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(32'hf2c6edba));
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk(32'({pll_en, byp, mode}), 32'h21);
        chk(32'({vbyp, ven, vlvl}), 32'h18);
        chk(32'(mult), 32'hA);
        wb(1'b0, `PMCC_ADR_LOCKCNT, 32'h0);
        chk(rd, 32'h200);
        wb(1'b0, 5'h14, 32'h0);
        chk(rd, 32'h0);
        // Settle well short of the lock count, so no lock wait is involved
        for (int i = 0; i < 4; i++) begin
            d = (i < 3) ? sdiv[i] : $urandom_range(15, 1);
            wb(1'b1, `PMCC_ADR_PLLDIV, 32'(i * 16 + d));
            repeat (40) @(posedge clk);
            ticks(8 * d * (1 << i), 8 * d, 8 * (1 << i));
        end
        wb(1'b1, `PMCC_ADR_LOCKCNT, 32'h4);
        m = 11 + $urandom_range(20, 0);
        wb(1'b1, `PMCC_ADR_PLLCTL, 32'(m));
        chk(32'(mult), 32'hA);
        repeat (8) @(posedge clk);
        chk(32'(mult), 32'(m));
        v = $urandom_range(63, 0);
        wb(1'b1, `PMCC_ADR_REGULATOR_CTRL_REG, 32'(v));
        chk(32'({vbyp, ven, vlvl}), 32'(v));
        // Sleep then wake, first with bypass clear, then with bypass set and PLL off
        for (int b = 0; b < 2; b++) begin
            wb(1'b1, `PMCC_ADR_PLLCTL, 32'(b * 768));
            repeat (2) @(posedge clk);
            chk(32'({dma, byp, mode}), mode_exp(b));
            chk(32'(pll_en), 32'(1 - b));
            if (b == 1) begin
                // The old core ratio runs out before the bypass ratio loads
                repeat (8) @(posedge clk);
                ticks(8 * d, 8 * d, 8);
            end
            wb(1'b1, `PMCC_ADR_PLLCTL, 32'(b * 256 + 1024));
            repeat (2) @(posedge clk);
            chk(32'({dma, byp, mode}), 32'h04);
            irq <= 1'b1;
            repeat (3) @(posedge clk);
            chk(32'({dma, byp, mode}), mode_exp(b));
            irq <= 1'b0;
        end
        wb(1'b1, `PMCC_ADR_PLLCTL, 32'h0);
        wb(1'b1, `PMCC_ADR_PLLCTL, 32'h800);
        irq <= 1'b1;
        repeat (4) @(posedge clk);
        chk(32'({blk, pll_en, mode}), 32'h28);
        irq <= 1'b0;
        rtc <= 1'b1;
        repeat (3) @(posedge clk);
        chk(32'({blk, mode}), 32'h1);
        rtc <= 1'b0;
        wb(1'b1, `PMCC_ADR_PLLCTL, 32'h800);
        repeat (3) @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        chk(32'({blk, pll_en, mode}), 32'h11);
        repeat (2) @(posedge clk);
        chk(32'({dma, blk, pll_en, mode}), 32'h51);
        report_and_stop();
    end
endmodule
